// ===== verilog/ssb_defs.vh
// constants for the burst address and sleep control block
// Contract
// - step/load high advances counter, uses counter address
// - step/load low registers external start address
// - counter wraps after four accesses
// - pick low gives linear low-bit order
// - pick high gives interleaved xor order
// - bypass low flow-through, high pipelined
// - sleep entered two cycles after request
// - asleep: deselected, inputs ignored, outputs off; bypass and pick still update PIPELINED_O and INTERLEAVED_O
// - stays asleep while requested, then recovers
// - every continue cycle inside a burst increments the counter unless edge qualify is high or asleep
// - edge qualify high holds address and burst state
// - burst counter is two bits wide
`ifndef SSB_DEFS_VH
`define SSB_DEFS_VH
`define SSB_SLEEP_DELAY      2
`define SSB_WAKE_NS          20
`define SSB_CLK_MHZ          200
`define SSB_CNT_W            2
`define SSB_CNT_ZERO         2'h0
`define SSB_CNT_ONE          2'h1
`define SSB_CNT_LAST         2'h3
`define SSB_ST_AWAKE         4'h1
`define SSB_ST_ENTER         4'h2
`define SSB_ST_ASLEEP        4'h4
`define SSB_ST_WAKE          4'h8
`endif

// ===== verilog/ssb_burst_counter.v
// two-bit burst counter with linear or interleaved address ordering
`timescale 1ns/1ps
`include "ssb_defs.vh"
module ssb_burst_counter (
  input  wire                  clk_i,
  input  wire                  rst_n_i,
  input  wire                  en_i,
  input  wire                  load_i,
  input  wire                  step_i,
  input  wire [`SSB_CNT_W-1:0] start_i,
  input  wire                  pick_i,
  output wire [`SSB_CNT_W-1:0] low_o,
  output wire                  wrap_o
);
  reg [`SSB_CNT_W-1:0] count;
  reg [`SSB_CNT_W-1:0] base;
  wire [`SSB_CNT_W-1:0] next_count;

  // count after the coming step; outputs look ahead so the step edge registers them
  assign next_count = count + `SSB_CNT_ONE;

  // address order from base and count; shared between both orderings
  function [`SSB_CNT_W-1:0] ssb_order;
    input [`SSB_CNT_W-1:0] b;
    input [`SSB_CNT_W-1:0] c;
    input                  p;
    begin
      if (p)
        ssb_order = b ^ c;
      else
        ssb_order = b + c;
    end
  endfunction

  // counter restarts at load; modulo four wrap comes free from the width
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= `SSB_CNT_ZERO;
      base  <= `SSB_CNT_ZERO;
    end else if (en_i) begin
      if (load_i) begin
        count <= `SSB_CNT_ZERO;
        base  <= start_i;
      end else if (step_i) begin
        count <= next_count;
      end
    end
  end

  // low bits and wrap flag of the access the next step makes; xor order is not base+count+1
  assign low_o  = ssb_order(base, next_count, pick_i);
  assign wrap_o = (next_count == `SSB_CNT_LAST);
endmodule

// ===== verilog/ssb_burst_sleep.v
// top: burst address generation, mode selection and sleep control
`timescale 1ns/1ps
`include "ssb_defs.vh"
module ssb_burst_sleep #(
  parameter ADDR_W   = 18,
  parameter WAKE_NS  = `SSB_WAKE_NS
) (
  input  wire              CLK_I,
  input  wire              RST_N_I,
  input  wire              CKE_N_I,
  input  wire              SELECT_I,
  input  wire              WRITE_N_I,
  input  wire              BYTE_WR_ANY_I,
  input  wire              COUNTER_STEP_OR_LOAD_I,
  input  wire [ADDR_W-1:0] ADDR_I,
  input  wire              BURST_SEQUENCE_PICK_I,
  input  wire              OUTPUT_REGISTER_BYPASS_I,
  input  wire              SLEEP_REQUEST_I,
  output reg  [ADDR_W-1:0] ACCESS_ADDR_O,
  output reg               ACCESS_VALID_O,
  output reg               ACCESS_WRITE_O,
  output reg               PIPELINED_O,
  output reg               INTERLEAVED_O,
  output reg               ASLEEP_O,
  output reg               RECOVERING_O,
  output reg               OUTPUT_EN_O,
  output reg               WRAP_O
);
  // recovery interval in cycles, rounded up, at least one
  localparam integer WAKE_CYC_RAW = (WAKE_NS * `SSB_CLK_MHZ + 999) / 1000;
  localparam integer WAKE_CYC     = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
  localparam [3:0]   ST_AWAKE     = `SSB_ST_AWAKE;
  localparam [3:0]   ST_ENTER     = `SSB_ST_ENTER;
  localparam [3:0]   ST_ASLEEP    = `SSB_ST_ASLEEP;
  localparam [3:0]   ST_WAKE      = `SSB_ST_WAKE;
  localparam [15:0]  WAKE_LOAD    = WAKE_CYC[15:0];
  localparam [1:0]   ENTER_LOAD   = `SSB_SLEEP_DELAY - 1;

  reg  [3:0]        state;
  reg  [3:0]        next_state;
  reg  [15:0]       wake_cnt;
  reg  [1:0]        enter_cnt;
  reg  [ADDR_W-1:0] upper;
  reg               in_burst;
  wire              sleeping;
  wire              edge_ok;
  wire              load;
  wire              step;
  wire [`SSB_CNT_W-1:0] low;
  wire              wrap;

  // asleep ignores every input but reset, the sleep request, bypass and pick
  assign sleeping = (state == ST_ASLEEP);
  assign edge_ok  = !CKE_N_I && !sleeping;
  assign load     = !COUNTER_STEP_OR_LOAD_I && SELECT_I;
  assign step     = COUNTER_STEP_OR_LOAD_I && in_burst;

  ssb_burst_counter u_cnt (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .en_i    (edge_ok),
    .load_i  (load),
    .step_i  (step),
    .start_i (ADDR_I[`SSB_CNT_W-1:0]),
    .pick_i  (BURST_SEQUENCE_PICK_I),
    .low_o   (low),
    .wrap_o  (wrap)
  );

  // sleep sequencing; request sampled directly since it may arrive any time
  always @* begin
    next_state = state;
    case (state)
      ST_AWAKE:  if (SLEEP_REQUEST_I) next_state = ST_ENTER;
      ST_ENTER:  if (!SLEEP_REQUEST_I) next_state = ST_AWAKE;
                 else if (enter_cnt == 2'h0) next_state = ST_ASLEEP;
      ST_ASLEEP: if (!SLEEP_REQUEST_I) next_state = ST_WAKE;
      ST_WAKE:   if (SLEEP_REQUEST_I) next_state = ST_ENTER;
                 else if (wake_cnt == 16'h0000) next_state = ST_AWAKE;
      default:   next_state = ST_AWAKE;
    endcase
  end

  // state and timers
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state     <= ST_AWAKE;
      enter_cnt <= 2'h0;
      wake_cnt  <= 16'h0000;
    end else begin
      state <= next_state;
      if (next_state == ST_ENTER && state != ST_ENTER)
        enter_cnt <= ENTER_LOAD;
      else if (enter_cnt != 2'h0)
        enter_cnt <= enter_cnt - 2'h1;
      if (next_state == ST_WAKE && state != ST_WAKE)
        wake_cnt <= WAKE_LOAD - 16'h0001;
      else if (wake_cnt != 16'h0000)
        wake_cnt <= wake_cnt - 16'h0001;
    end
  end

  // upper address and burst tracking; held over stalls and sleep so state survives
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      upper    <= {ADDR_W{1'b0}};
      in_burst <= 1'b0;
    end else if (edge_ok) begin
      if (load) begin
        upper    <= ADDR_I;
        in_burst <= 1'b1;
      end else if (!COUNTER_STEP_OR_LOAD_I) begin
        in_burst <= 1'b0;    // deselect ends the burst
      end
    end
  end

  // registered outputs; access address reflects the counter for the current cycle
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ACCESS_ADDR_O  <= {ADDR_W{1'b0}};
      ACCESS_VALID_O <= 1'b0;
      ACCESS_WRITE_O <= 1'b0;
      PIPELINED_O    <= 1'b1;
      INTERLEAVED_O  <= 1'b0;
      ASLEEP_O       <= 1'b0;
      RECOVERING_O   <= 1'b0;
      OUTPUT_EN_O    <= 1'b0;
      WRAP_O         <= 1'b0;
    end else begin
      PIPELINED_O   <= OUTPUT_REGISTER_BYPASS_I;
      INTERLEAVED_O <= BURST_SEQUENCE_PICK_I;
      ASLEEP_O      <= (next_state == ST_ASLEEP);
      RECOVERING_O  <= (next_state == ST_WAKE);
      // quiet from the same edge that raises the asleep flag
      if (sleeping || next_state == ST_ASLEEP) begin
        ACCESS_VALID_O <= 1'b0;
        OUTPUT_EN_O    <= 1'b0;
      end else if (edge_ok) begin
        if (load) begin
          ACCESS_ADDR_O  <= ADDR_I;
          ACCESS_VALID_O <= 1'b1;
          ACCESS_WRITE_O <= !WRITE_N_I && BYTE_WR_ANY_I;
          OUTPUT_EN_O    <= WRITE_N_I;
          WRAP_O         <= 1'b0;
        end else if (step) begin
          ACCESS_ADDR_O  <= {upper[ADDR_W-1:`SSB_CNT_W], low};
          ACCESS_VALID_O <= 1'b1;
          ACCESS_WRITE_O <= BYTE_WR_ANY_I && ACCESS_WRITE_O;
          WRAP_O         <= wrap;
        end else begin
          ACCESS_VALID_O <= 1'b0;
          OUTPUT_EN_O    <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== tb/ssb_burst_sleep_assertions.sv
// checker for burst order, stall and sleep timing
`timescale 1ns/1ps
module ssb_burst_sleep_chk #(parameter ADDR_W = 18) (
  input wire              CLK_I, RST_N_I, CKE_N_I, SELECT_I, COUNTER_STEP_OR_LOAD_I, SLEEP_REQUEST_I,
  input wire              BURST_SEQUENCE_PICK_I, OUTPUT_REGISTER_BYPASS_I, ACCESS_VALID_O, PIPELINED_O,
  input wire              ASLEEP_O, RECOVERING_O, OUTPUT_EN_O, WRAP_O,
  input wire [ADDR_W-1:0] ADDR_I, ACCESS_ADDR_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // an edge counts only when not stalled and sleep is neither requested nor running
  wire take = !CKE_N_I && !SLEEP_REQUEST_I && !ASLEEP_O && !RECOVERING_O;
  sequence s_load; take && SELECT_I && !COUNTER_STEP_OR_LOAD_I; endsequence
  sequence s_step; take && COUNTER_STEP_OR_LOAD_I && ACCESS_VALID_O; endsequence
  property p_load; s_load |=> ACCESS_VALID_O && ACCESS_ADDR_O == $past(ADDR_I); endproperty
  a_load: assert property (p_load) else $error("load address wrong");
  property p_lin; s_step ##0 !BURST_SEQUENCE_PICK_I |=> ACCESS_ADDR_O[1:0] == $past(ACCESS_ADDR_O[1:0]) + 2'h1
    && ACCESS_ADDR_O[ADDR_W-1:2] == $past(ACCESS_ADDR_O[ADDR_W-1:2]); endproperty
  a_lin: assert property (p_lin) else $error("linear step wrong");
  property p_wrap; s_load ##1 s_step [*3] |=> WRAP_O; endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap flag");
  property p_stall; CKE_N_I && !ASLEEP_O |=> $stable(ACCESS_ADDR_O) && $stable(WRAP_O); endproperty
  a_stall: assert property (p_stall) else $error("stall moved state");
  property p_enter; $rose(SLEEP_REQUEST_I) |-> !ASLEEP_O [*3] ##1 ASLEEP_O; endproperty
  a_enter: assert property (p_enter) else $error("sleep entry time");
  property p_off; ASLEEP_O |-> !ACCESS_VALID_O && !OUTPUT_EN_O; endproperty
  a_off: assert property (p_off) else $error("active while asleep");
  property p_wake; $fell(SLEEP_REQUEST_I) |-> ##[1:6] !ASLEEP_O && !RECOVERING_O; endproperty
  a_wake: assert property (p_wake) else $error("wake too slow");
  property p_mode; take |=> PIPELINED_O == $past(OUTPUT_REGISTER_BYPASS_I); endproperty
  a_mode: assert property (p_mode) else $error("pipeline select wrong");
endmodule

// ===== tb/ssb_ctrl_model.sv
// controller model driving commands, modes and sleep request
`timescale 1ns/1ps
module ssb_ctrl_model (
  input  wire        CLK_I,
  output reg         CKE_N_I, SELECT_I, COUNTER_STEP_OR_LOAD_I, SLEEP_REQUEST_I,
  output reg         BURST_SEQUENCE_PICK_I, OUTPUT_REGISTER_BYPASS_I,
  output reg  [17:0] ADDR_I
);
  // idle deselected and awake; bypass starts high as an open pin would
  initial {CKE_N_I, SELECT_I, COUNTER_STEP_OR_LOAD_I, SLEEP_REQUEST_I, BURST_SEQUENCE_PICK_I} = 5'h00;
  initial {OUTPUT_REGISTER_BYPASS_I, ADDR_I} = 19'h4_0000;
  // new command just after the edge, held until the next call
  task put(input k, s, a, z, input [17:0] d);
    @(posedge CLK_I);
    #1 {CKE_N_I, SELECT_I, COUNTER_STEP_OR_LOAD_I, SLEEP_REQUEST_I, ADDR_I} = {k, s, a, z, d};
  endtask
endmodule

// ===== tb/ssb_burst_sleep_tb.sv
// testbench: burst order, stall, mode pin and sleep
`timescale 1ns/1ps
module ssb_burst_sleep_tb;
  logic CLK_I = 1'b0, RST_N_I = 1'b0, WRITE_N_I = 1'b1, BYTE_WR_ANY_I = 1'b0;
  wire CKE_N_I, SELECT_I, COUNTER_STEP_OR_LOAD_I, SLEEP_REQUEST_I, BURST_SEQUENCE_PICK_I;
  wire OUTPUT_REGISTER_BYPASS_I, ACCESS_VALID_O, ACCESS_WRITE_O, PIPELINED_O, INTERLEAVED_O;
  wire ASLEEP_O, RECOVERING_O, OUTPUT_EN_O, WRAP_O;
  wire [17:0] ADDR_I, ACCESS_ADDR_O;
  int err_total = 0, n_compared = 0, cyc = 0;
  ssb_burst_sleep dut (.*);
  ssb_ctrl_model ctl (.*);
  always #2.5 CLK_I = ~CLK_I;
  task chk(input bit c, input string m);
    n_compared++;
    if (!c) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // five accesses from one load; steps carry a wrong address on purpose
  task t_burst(input p, input [1:0] b);
    logic [17:0] base;
    base = {16'ha5c3, b};
    ctl.BURST_SEQUENCE_PICK_I = p;
    ctl.put(0, 1, 0, 0, base);
    for (int i = 0; i < 5; i++) begin
      ctl.put(0, 1, 1, 0, ~base);
      chk(ACCESS_ADDR_O === {base[17:2], p ? b ^ i[1:0] : b + i[1:0]}, "burst address");
      chk(WRAP_O === (i == 3) && INTERLEAVED_O === p, "wrap or order flag");
    end
    ctl.put(0, 0, 0, 0, 18'h0_0000);
  endtask
  // two ignored edges between a load and its step
  task t_stall;
    ctl.put(0, 1, 0, 0, 18'h1_0002);
    repeat (2) ctl.put(1, 1, 1, 0, 18'h0_0000);
    chk(ACCESS_ADDR_O === 18'h1_0002, "stall moved address");
    ctl.put(0, 1, 1, 0, 18'h0_0000);
    ctl.put(0, 0, 0, 0, 18'h0_0000);
    chk(ACCESS_ADDR_O === 18'h1_0003, "step after stall");
  endtask
  // write load then a write-abort continue cycle
  task t_write;
    WRITE_N_I = 1'b0;
    BYTE_WR_ANY_I = 1'b1;
    ctl.put(0, 1, 0, 0, 18'h0_0010);
    ctl.put(0, 1, 1, 0, 18'h0_0000);
    chk(ACCESS_WRITE_O === 1'b1 && OUTPUT_EN_O === 1'b0, "write load");
    BYTE_WR_ANY_I = 1'b0;
    ctl.put(0, 0, 0, 0, 18'h0_0000);
    chk(ACCESS_WRITE_O === 1'b0 && ACCESS_ADDR_O === 18'h0_0011, "abort step");
    WRITE_N_I = 1'b1;
  endtask
  task t_mode;
    for (int m = 0; m < 2; m++) begin
      ctl.OUTPUT_REGISTER_BYPASS_I = m[0];
      repeat (2) ctl.put(0, 0, 0, 0, 18'h0_0000);
      chk(PIPELINED_O === m[0], "pipeline select");
    end
  endtask
  // sleep raised only with nothing pending; loads while asleep must be lost
  task t_sleep;
    repeat (3) ctl.put(0, 0, 0, 1, 18'h0_0000);
    chk(ASLEEP_O === 1'b0, "asleep too early");
    ctl.put(0, 0, 0, 1, 18'h0_0000);
    chk(ASLEEP_O === 1'b1, "not asleep");
    repeat (4) ctl.put(0, 1, 0, 1, 18'h0_0003);
    chk(!ACCESS_VALID_O && !OUTPUT_EN_O && ASLEEP_O, "inputs not ignored");
    repeat (7) ctl.put(0, 0, 0, 0, 18'h0_0000);
    chk(ASLEEP_O === 1'b0 && RECOVERING_O === 1'b0, "no wake");
    ctl.put(0, 1, 0, 0, 18'h2_0001);
    ctl.put(0, 0, 0, 0, 18'h0_0000);
    chk(ACCESS_VALID_O && ACCESS_ADDR_O === 18'h2_0001, "access after wake");
  endtask
  // hang guard far beyond the ninety or so cycles needed
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge CLK_I);
    #1 RST_N_I = 1'b1;
    t_mode();
    $display("mode test done");
    for (int c = 0; c < 8; c++) t_burst(c[2], c[1:0]);
    $display("burst test done");
    t_stall();
    $display("stall test done");
    t_write();
    $display("write test done");
    t_sleep();
    $display("sleep test done");
    stop_test();
  end
endmodule
bind ssb_burst_sleep ssb_burst_sleep_chk #(.ADDR_W(ADDR_W)) chk (.*);
